// ==== inc/qfd_pkg.sv ====
// Constants, register map and state types for the quad-channel fault diagnostics controller.
package qfd_pkg;

    localparam int NCH    = 4;
    localparam int ADC_W  = 10;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 8;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] ADR_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] ADR_THR   = 4'h4;
    localparam logic [ADDR_W-1:0] ADR_STAT  = 4'h8;
    localparam logic [ADDR_W-1:0] ADR_SENSE = 4'hc;

    // Control register fields.
    localparam int CB_ON    = 0;
    localparam int CB_GATE  = 4;
    localparam int CB_TLAT  = 5;
    localparam int CB_AUTO  = 6;
    localparam int CB_AOFF  = 7;
    localparam int CB_LOWP  = 8;
    localparam int CB_MSEL  = 9;
    localparam int CB_START = 11;

    // Threshold register fields.
    localparam int TB_FLT = 0;
    localparam int TB_OL  = 16;

    // Status register fields.
    localparam int SB_FLT   = 0;
    localparam int SB_OL    = 4;
    localparam int SB_BUSY  = 8;
    localparam int SB_FLINE = 9;
    localparam int SB_IDX   = 10;

    localparam logic [ADC_W-1:0] FLT_THR_RST = 10'h300;
    localparam logic [ADC_W-1:0] OL_THR_RST  = 10'h008;
    localparam logic [1:0]       LAST_CH     = 2'h3;

    // Sense settling time after each selector change.
    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_NS     = 20000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC - 1);
    localparam int SCAN_CYC      = NCH * (SETTLE_CYC + 1) + 1;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_FINISH = 2'b11
    } qfd_state_t;

    typedef struct packed {
        logic [NCH-1:0]    chan_on;
        logic              gate;
        logic              tlat;
        logic              auto_scan;
        logic              auto_off;
        logic              low_pow;
        logic [1:0]        man_sel;
        logic [ADC_W-1:0]  flt_thr;
        logic [ADC_W-1:0]  ol_thr;
        logic [NCH-1:0]    flt_seen;
        logic [NCH-1:0]    ol_seen;
        logic [ADC_W-1:0]  last_code;
        qfd_state_t        st;
        logic [1:0]        idx;
        logic [CNT_W-1:0]  cnt;
        logic [DATA_W-1:0] rdata;
        logic [NCH-1:0]    pin_on;
        logic              pin_gate;
        logic [1:0]        pin_sel;
        logic              pin_tlat;
    } qfd_regs_t;

endpackage

// ==== core/qfd_ctrl.sv ====
// Host-side controller that drives and scans a quad-channel protected switch's diagnostics.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps

module qfd_ctrl
    import qfd_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_stb_i,
    input  wire logic              rd_stb_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              fault_line_n_i,
    input  wire logic [ADC_W-1:0]  sense_code_i,
    output logic                   diagnostics_gate_o,
    output logic      [NCH-1:0]    channel_on_o,
    output logic                   select_high_bit_o,
    output logic                   select_low_bit_o,
    output logic                   thermal_latch_select_o
);

    qfd_regs_t         r;
    qfd_regs_t         n;
    logic              start;
    logic              busy;
    logic [DATA_W-1:0] stat_word;

    assign busy = (r.st != ST_IDLE);

    always_comb
    begin
        stat_word                      = '0;
        stat_word[SB_FLT +: NCH]       = r.flt_seen;
        stat_word[SB_OL +: NCH]        = r.ol_seen;
        stat_word[SB_BUSY]             = busy;
        stat_word[SB_FLINE]            = !fault_line_n_i;
        stat_word[SB_IDX +: 2]         = r.idx;
    end

    always_comb
    begin
        n       = r;
        n.rdata = '0;
        start   = 1'b0;
        if (wr_stb_i)
        begin
            if (addr_i == ADR_CTRL)
            begin
                n.chan_on   = wdata_i[CB_ON +: NCH];
                n.gate      = wdata_i[CB_GATE];
                n.tlat      = wdata_i[CB_TLAT];
                n.auto_scan = wdata_i[CB_AUTO];
                n.auto_off  = wdata_i[CB_AOFF];
                n.low_pow   = wdata_i[CB_LOWP];
                n.man_sel   = wdata_i[CB_MSEL +: 2];
                start       = wdata_i[CB_START];
            end
            else if (addr_i == ADR_THR)
            begin
                n.flt_thr = wdata_i[TB_FLT +: ADC_W];
                n.ol_thr  = wdata_i[TB_OL +: ADC_W];
            end
        end
        if (rd_stb_i)
        begin
            unique case (addr_i)
                ADR_CTRL:
                begin
                    n.rdata[CB_ON +: NCH]  = r.chan_on;
                    n.rdata[CB_GATE]       = r.gate;
                    n.rdata[CB_TLAT]       = r.tlat;
                    n.rdata[CB_AUTO]       = r.auto_scan;
                    n.rdata[CB_AOFF]       = r.auto_off;
                    n.rdata[CB_LOWP]       = r.low_pow;
                    n.rdata[CB_MSEL +: 2]  = r.man_sel;
                end
                ADR_THR:
                begin
                    n.rdata[TB_FLT +: ADC_W] = r.flt_thr;
                    n.rdata[TB_OL +: ADC_W]  = r.ol_thr;
                end
                ADR_STAT:  n.rdata = stat_word;
                ADR_SENSE: n.rdata[ADC_W-1:0] = r.last_code;
                default:   n.rdata = '0;
            endcase
        end

        unique case (r.st)
            ST_IDLE:
            begin
                // The pulled-up fault line reads low only while the device reports.
                if (!n.low_pow && (start || (n.auto_scan && !fault_line_n_i)))
                begin
                    n.st       = ST_SETTLE;
                    n.idx      = 2'h0;
                    n.cnt      = SETTLE_LOAD;
                    n.flt_seen = '0;
                    n.ol_seen  = '0;
                end
            end
            ST_SETTLE:
            begin
                if (r.cnt == '0)
                    n.st = ST_SAMPLE;
                else
                    n.cnt = r.cnt - 1'b1;
            end
            ST_SAMPLE:
            begin
                n.last_code = sense_code_i;
                // An off channel can only report open load if the board pull-up lifts it.
                // A faulted channel pins sense at the fault pull-up level.
                if (sense_code_i >= r.flt_thr)
                    n.flt_seen[r.idx] = 1'b1;
                // An enabled channel with almost no sense current has lost its load.
                if (r.chan_on[r.idx] && (sense_code_i < r.ol_thr))
                    n.ol_seen[r.idx] = 1'b1;
                if (r.idx == LAST_CH)
                    n.st = ST_FINISH;
                else
                begin
                    n.idx = r.idx + 1'b1;
                    n.cnt = SETTLE_LOAD;
                    n.st  = ST_SETTLE;
                end
            end
            ST_FINISH:
            begin
                // Faulted channels are switched off so they stop heating.
                if (r.auto_off)
                    n.chan_on = n.chan_on & ~r.flt_seen;
                n.st = ST_IDLE;
            end
        endcase

        // Entering low power abandons a scan so the gate can drop at once.
        if (n.low_pow && (n.st != ST_IDLE))
            n.st = ST_IDLE;

        n.pin_gate = !n.low_pow && (n.gate || (n.st != ST_IDLE));
        n.pin_on   = n.low_pow ? '0 : n.chan_on;
        n.pin_sel  = (n.st == ST_IDLE) ? n.man_sel : n.idx;
        n.pin_tlat = n.tlat;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            r         <= '0;
            r.flt_thr <= FLT_THR_RST;
            r.ol_thr  <= OL_THR_RST;
        end
        else
            r <= n;
    end

    assign rdata_o                = r.rdata;
    assign diagnostics_gate_o     = r.pin_gate;
    assign channel_on_o           = r.pin_on;
    assign select_high_bit_o      = r.pin_sel[1];
    assign select_low_bit_o       = r.pin_sel[0];
    assign thermal_latch_select_o = r.pin_tlat;

    // Checking logic below; only the assertions read it.
    int busy_len;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i || !busy)
            busy_len <= 0;
        else
            busy_len <= busy_len + 1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_low_power_pins: assert property (
        r.low_pow |-> (!diagnostics_gate_o && (channel_on_o == '0)))
        else $error("low power mode left gate or enables driven");

    a_scan_gate_open: assert property (
        busy |-> diagnostics_gate_o)
        else $error("diagnostics gate low during a scan");

    a_scan_on_fault: assert property (
        (!busy && r.auto_scan && !r.low_pow && !fault_line_n_i && !wr_stb_i)
        |=> (r.st == ST_SETTLE) && (r.idx == 2'h0) && (r.cnt == SETTLE_LOAD))
        else $error("fault line low did not start a scan");

    a_sel_tracks_idx: assert property (
        busy |-> ({select_high_bit_o, select_low_bit_o} == r.idx))
        else $error("selector pins differ from scanned channel");

    a_scan_duration: assert property (
        ($fell(busy) && !r.low_pow) |-> (busy_len == SCAN_CYC))
        else $error("scan did not last the expected number of cycles");

    a_fault_flagged: assert property (
        ((r.st == ST_SAMPLE) && (sense_code_i >= r.flt_thr) && !$rose(r.low_pow))
        ##1 !r.low_pow |-> r.flt_seen[$past(r.idx)])
        else $error("high sense level not recorded as a fault");

    a_open_load_flag: assert property (
        ((r.st == ST_SAMPLE) && r.chan_on[r.idx] && (sense_code_i < r.ol_thr))
        |=> r.ol_seen[$past(r.idx)])
        else $error("low sense on enabled channel not recorded");

    a_auto_turn_off: assert property (
        ((r.st == ST_FINISH) && r.auto_off && !wr_stb_i)
        |=> ((r.chan_on & $past(r.flt_seen)) == '0) && ((channel_on_o & r.flt_seen) == '0))
        else $error("faulted channel left on after scan");

    a_status_read: assert property (
        (rd_stb_i && (addr_i == ADR_STAT)) |=> (rdata_o == $past(stat_word)))
        else $error("status read returned wrong word");

    c_fault_scan: cover property (!fault_line_n_i && r.auto_scan ##1 $rose(busy));
    c_fault_found: cover property ((r.st == ST_FINISH) && (r.flt_seen != '0));
    c_open_load: cover property ((r.st == ST_FINISH) && (r.ol_seen != '0));
    c_auto_off: cover property ((r.st == ST_FINISH) && r.auto_off && ((r.chan_on & r.flt_seen) != '0));

endmodule

// ==== verif/qfd_dev_model.sv ====
// Behavioural model of the quad switch's diagnostics pins as the controller sees them.
`timescale 1ns/10ps
module qfd_dev_model
    import qfd_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 gate_i,
    input  wire logic [NCH-1:0]       on_i,
    input  wire logic                 sel_hi_i,
    input  wire logic                 sel_lo_i,
    input  wire logic                 tlat_i,
    input  wire logic [NCH-1:0]       tsd_i,
    input  wire logic [NCH-1:0]       ovl_i,
    input  wire logic [NCH-1:0]       ol_i,
    input  wire logic [NCH*ADC_W-1:0] lin_i,
    output logic                      fault_n_o,
    output logic      [ADC_W-1:0]     code_o
);
    logic [NCH-1:0]   flt;
    logic [1:0]       sel;
    logic [ADC_W-1:0] junk = 10'h155;
    logic [NCH-1:0]   tsd_hold = '0;

    // A floating sense pin is read as a code that changes every cycle, never a held value.
    always @(posedge clk_i)
        junk <= ~junk + 10'h001;

    // A shutdown flag is dropped when the enable goes low; cooling clears it only in retry mode.
    // The reduced limit after shutdown only scales the load current, so pins show the flag alone.
    always @(posedge clk_i)
        tsd_hold <= on_i & (tsd_i | (tsd_hold & {NCH{tlat_i}}));

    assign sel = {sel_hi_i, sel_lo_i};
    assign flt = (on_i & ovl_i) | tsd_hold | (~on_i & ol_i);
    // The fault line has a pull-up, so released means high.
    assign fault_n_o = ~(gate_i & |flt);

    always_comb
    begin
        if (!gate_i)
            code_o = junk;
        else if (flt[sel])
            code_o = 10'h3ff;
        else if (on_i[sel] && ol_i[sel])
            code_o = 10'h002;
        else if (on_i[sel])
            code_o = lin_i[sel*ADC_W +: ADC_W];
        else
            code_o = 10'h000;
    end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the quad-channel diagnostics controller.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", nm, e, a); end end
module tb_top;
    import qfd_pkg::*;
    logic                 ref_clk_i = 0;
    logic                 sys_rst_i = 1;
    logic                 wr_stb_i  = 0;
    logic                 rd_stb_i  = 0;
    logic                 rd_d      = 0;
    logic [ADDR_W-1:0]    addr      = '0;
    logic [DATA_W-1:0]    wdata     = '0;
    logic [DATA_W-1:0]    rdata;
    logic                 fline_n;
    logic [ADC_W-1:0]     code;
    logic                 gate, sh, sl, tl;
    logic [NCH-1:0]       on;
    logic [NCH-1:0]       ovl = '0;
    logic [NCH-1:0]       ol  = '0;
    logic [NCH-1:0]       tsd = '0;
    logic [NCH*ADC_W-1:0] lin = '0;
    logic [63:0]          q[$];
    logic [63:0]          note;
    logic [31:0]          seed = 32'h2645e566;
    int                   n_errors = 0;
    int                   check_count = 0;

    qfd_ctrl uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rdata_o(rdata), .fault_line_n_i(fline_n),
        .sense_code_i(code), .diagnostics_gate_o(gate), .channel_on_o(on),
        .select_high_bit_o(sh), .select_low_bit_o(sl), .thermal_latch_select_o(tl));
    qfd_dev_model dev (.clk_i(ref_clk_i), .gate_i(gate), .on_i(on), .sel_hi_i(sh),
        .sel_lo_i(sl), .tlat_i(tl), .tsd_i(tsd), .ovl_i(ovl), .ol_i(ol), .lin_i(lin),
        .fault_n_o(fline_n), .code_o(code));

    always #50 ref_clk_i = ~ref_clk_i;

    // Read data stands only in the cycle after the strobe, so the oldest note is taken then.
    always @(negedge ref_clk_i)
    begin
        if (rd_d)
        begin
            note = q.pop_front();
            `CHK("rdata", note[63:32], rdata & note[31:0])
        end
        rd_d = rd_stb_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr_stb_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, m);
        q.push_back({e, m});
        @(posedge ref_clk_i);
        addr <= a;
        rd_stb_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_stb_i <= 1'b0;
    endtask

    task automatic results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        results();
    end

    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK("pins", 8'h00, {gate, on, sh, sl, tl})
        rd(ADR_CTRL, 32'h0, '1);
        rd(ADR_THR, 32'h0008_0300, '1);
        rd(4'h2, 32'h0, '1);
        for (int s = 0; s < 4; s++)
        begin
            wr(ADR_CTRL, 32'h0000_0030 | (32'(s) << 9));
            @(posedge ref_clk_i);
            #1;
            `CHK("sel", {1'b1, 2'(s), 1'b1}, {gate, sh, sl, tl})
        end
        rd(ADR_CTRL, 32'h0000_0630, '1);
        wr(ADR_CTRL, 32'h0000_011f);
        @(posedge ref_clk_i);
        #1;
        `CHK("lowpow", 5'h00, {gate, on})
        seed = xs(seed);
        lin[0 +: ADC_W] <= 10'h010 + 10'(seed % 32'h2e0);
        seed = xs(seed);
        lin[3*ADC_W +: ADC_W] <= 10'h010 + 10'(seed % 32'h2e0);
        lin[ADC_W +: 2*ADC_W] <= {10'h100, 10'h080};
        ol <= 4'b0010;
        ovl <= 4'b0100;
        wr(ADR_CTRL, 32'h0000_081f);
        repeat (100) @(posedge ref_clk_i);
        #1;
        `CHK("scan1", 3'b100, {gate, sh, sl})
        repeat (200) @(posedge ref_clk_i);
        #1;
        `CHK("scan2", 3'b101, {gate, sh, sl})
        repeat (SCAN_CYC) @(posedge ref_clk_i);
        rd(ADR_STAT, 32'h0000_0224, 32'h0000_03ff);
        rd(ADR_SENSE, {22'h0, lin[3*ADC_W +: ADC_W]}, '1);
        ovl <= 4'b0001;
        wr(ADR_CTRL, 32'h0000_089f);
        repeat (SCAN_CYC + 2) @(posedge ref_clk_i);
        #1;
        `CHK("autooff", 4'b1110, on)
        rd(ADR_STAT, 32'h0000_0021, 32'h0000_03ff);
        // Thermal shutdown in retry mode clears as soon as the channel cools.
        ovl <= '0;
        ol <= '0;
        wr(ADR_CTRL, 32'h0000_001f);
        tsd <= 4'b0100;
        rd(ADR_STAT, 32'h0000_0200, 32'h0000_0200);
        tsd <= '0;
        rd(ADR_STAT, 32'h0, 32'h0000_0200);
        // In latch mode the fault outlives the heat until an enable toggle, or a return to retry mode, clears it.
        wr(ADR_CTRL, 32'h0000_003f);
        tsd <= 4'b0100;
        @(posedge ref_clk_i);
        tsd <= '0;
        rd(ADR_STAT, 32'h0000_0200, 32'h0000_0200);
        wr(ADR_CTRL, 32'h0000_003b);
        wr(ADR_CTRL, 32'h0000_003f);
        rd(ADR_STAT, 32'h0, 32'h0000_0200);
        // A fault with auto scan on starts the scan by itself and auto-off ends it.
        ovl <= 4'b1000;
        wr(ADR_CTRL, 32'h0000_00df);
        repeat (SCAN_CYC + 3) @(posedge ref_clk_i);
        #1;
        `CHK("autoscan", 4'b0111, on)
        rd(ADR_STAT, 32'h0000_0008, 32'h0000_03ff);
        repeat (3) @(posedge ref_clk_i);
        results();
    end
endmodule
